/* common/lim_pkg.sv */
// constants and types shared by the interface manage command controller
`default_nettype none
package lim_pkg;
    localparam logic [7:0] LIM_CLA = 8'h80;
    localparam logic [7:0] LIM_INS = 8'h76;
    localparam logic [7:0] LIM_OP_SELECT = 8'h00;
    localparam logic [7:0] LIM_OP_RESET = 8'h01;
    localparam logic [7:0] LIM_OP_ASSIGN = 8'h02;
    localparam logic [7:0] LIM_OP_RETRIEVE = 8'h03;
    localparam logic [7:0] LIM_OP_CONFIG = 8'h04;
    localparam logic [7:0] LIM_IF_MAX = 8'h1f;
    localparam logic [7:0] LIM_ZERO = 8'h00;
    localparam logic [7:0] LIM_LE_ANY = 8'h00;
    localparam logic [7:0] LIM_TAG_HIGH = 8'h80;
    localparam logic [7:0] LIM_TAG_OPT = 8'h81;
    localparam logic [7:0] LIM_TLV_LEN1 = 8'h01;
    localparam logic [7:0] LIM_CFG_LC_SHORT = 8'h03;
    localparam logic [7:0] LIM_CFG_LC_LONG = 8'h06;
    localparam logic [7:0] LIM_NONE_ASSIGNED = 8'hff;
    localparam logic [7:0] LIM_OPT_NAD_MASK = 8'h01;
    localparam logic [7:0] LIM_SW_OK = 8'h90;
    localparam logic [3:0] LIM_HDR_BYTES = 4'h4;
    typedef enum logic [3:0] {
        LIM_IDLE = 4'h0,
        LIM_HDR = 4'h1,
        LIM_LC = 4'h2,
        LIM_DATA = 4'h3,
        LIM_LE = 4'h4,
        LIM_RESP = 4'h5,
        LIM_DONE = 4'h6
    } lim_state_e;
endpackage : lim_pkg
`default_nettype wire

/* hw/lim_resp_parse.sv */
// parser of the card response bytes to an interface manage command
`default_nettype none
module lim_resp_parse
    import lim_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] op,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic [7:0] high_if,
    output logic high_seen,
    output logic [7:0] opt_bits,
    output logic [7:0] assigned_if,
    output logic [7:0] atr_len,
    output logic [7:0] data_byte,
    output logic data_strobe
);
    logic [7:0] idx;
    logic [7:0] next_idx;
    logic [7:0] tag;
    logic [7:0] next_tag;
    logic [7:0] len;
    logic [7:0] next_len;
    logic [7:0] next_high_if;
    logic next_high_seen;
    logic [7:0] next_opt_bits;
    logic [7:0] next_assigned_if;
    logic [7:0] next_atr_len;
    logic [7:0] next_data_byte;
    logic next_data_strobe;
    logic [7:0] pos;

    always_comb
    begin
        next_idx = idx;
        next_tag = tag;
        next_len = len;
        next_high_if = high_if;
        next_high_seen = high_seen;
        next_opt_bits = opt_bits;
        next_assigned_if = assigned_if;
        next_atr_len = atr_len;
        next_data_byte = data_byte;
        next_data_strobe = 1'b0;
        pos = 8'h00;
        if (start)
        begin
            next_idx = 8'h00;
            next_high_seen = 1'b0;
            next_opt_bits = 8'h00; // absent options read as zero
            next_atr_len = 8'h00;
        end
        else if (rx_valid)
        begin
            next_idx = idx + 8'h01;
            next_data_byte = rx_byte;
            next_data_strobe = 1'b1;
            pos = idx;
            if (op == LIM_OP_RESET || op == LIM_OP_ASSIGN)
            begin
                if (pos == 8'h01)
                begin
                    next_atr_len = rx_byte; // answer-to-reset wrapped in tlv
                end
            end
            else if (op == LIM_OP_RETRIEVE)
            begin
                if (pos == 8'h02)
                begin
                    next_assigned_if = rx_byte; // ff means none assigned
                end
            end
            else if (op == LIM_OP_CONFIG)
            begin
                // tlv walk: tag, length, one value byte
                if (pos % 8'h03 == 8'h00)
                begin
                    next_tag = rx_byte;
                end
                else if (pos % 8'h03 == 8'h01)
                begin
                    next_len = rx_byte;
                end
                else if (tag == LIM_TAG_HIGH)
                begin
                    next_high_if = rx_byte;
                    next_high_seen = 1'b1;
                end
                else if (tag == LIM_TAG_OPT)
                begin
                    next_opt_bits = rx_byte & LIM_OPT_NAD_MASK;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx <= 8'h00;
            tag <= 8'h00;
            len <= 8'h00;
            high_if <= 8'h00;
            high_seen <= 1'b0;
            opt_bits <= 8'h00;
            assigned_if <= LIM_NONE_ASSIGNED;
            atr_len <= 8'h00;
            data_byte <= 8'h00;
            data_strobe <= 1'b0;
        end
        else
        begin
            idx <= next_idx;
            tag <= next_tag;
            len <= next_len;
            high_if <= next_high_if;
            high_seen <= next_high_seen;
            opt_bits <= next_opt_bits;
            assigned_if <= next_assigned_if;
            atr_len <= next_atr_len;
            data_byte <= next_data_byte;
            data_strobe <= next_data_strobe;
        end
    end
endmodule : lim_resp_parse
`default_nettype wire

/* hw/lim_host.sv */
// terminal-side controller issuing interface manage commands to the card
`default_nettype none
module lim_host
    import lim_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic session_start,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_if,
    input wire logic [7:0] cmd_high,
    input wire logic [7:0] cmd_opt,
    input wire logic cmd_opt_present,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_last,
    output logic done,
    output logic rejected,
    output logic [7:0] sw1,
    output logic [7:0] sw2,
    output logic [7:0] selected_if,
    output logic [7:0] session_high,
    output logic nad_mode,
    output logic [7:0] assigned_if,
    output logic [7:0] atr_len,
    output logic [7:0] resp_byte,
    output logic resp_strobe,
    output logic configured
);
    logic rst_meta;
    logic rst_n;
    logic rx_valid_s1;
    logic rx_valid_s2;
    logic rx_last_s1;
    logic rx_last_s2;
    logic [7:0] rx_byte_s1;
    logic [7:0] rx_byte_s2;
    lim_state_e state;
    lim_state_e next_state;
    logic [7:0] op;
    logic [7:0] next_op;
    logic [7:0] p2;
    logic [7:0] next_p2;
    logic [7:0] high;
    logic [7:0] next_high;
    logic [7:0] opt;
    logic [7:0] next_opt;
    logic opt_on;
    logic next_opt_on;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_done;
    logic next_rejected;
    logic [7:0] next_sw1;
    logic [7:0] next_sw2;
    logic [7:0] next_selected_if;
    logic [7:0] next_session_high;
    logic next_nad_mode;
    logic next_configured;
    logic [7:0] p_high;
    logic p_high_seen;
    logic [7:0] p_opt;
    logic [7:0] p_assigned;
    logic bad;
    logic [7:0] lc;

    // card bytes arrive from outside this clock, so both strobe and data are synchronised
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
            rx_valid_s1 <= 1'b0;
            rx_valid_s2 <= 1'b0;
            rx_last_s1 <= 1'b0;
            rx_last_s2 <= 1'b0;
            rx_byte_s1 <= 8'h00;
            rx_byte_s2 <= 8'h00;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
            rx_valid_s1 <= rx_valid;
            rx_valid_s2 <= rx_valid_s1;
            rx_last_s1 <= rx_last;
            rx_last_s2 <= rx_last_s1;
            rx_byte_s1 <= rx_byte;
            rx_byte_s2 <= rx_byte_s1;
        end
    end

    function automatic logic [7:0] lim_tx_at(input logic [3:0] i, input logic [7:0] o,
        input logic [7:0] pp2, input logic [7:0] l, input logic [7:0] h,
        input logic [7:0] ob);
        logic [7:0] r;
        r = 8'h00;
        unique case (i)
            4'h0: r = LIM_CLA;
            4'h1: r = LIM_INS;
            4'h2: r = o;
            4'h3: r = pp2;
            4'h4: r = l;
            4'h5: r = LIM_TAG_HIGH;
            4'h6: r = LIM_TLV_LEN1;
            4'h7: r = h;
            4'h8: r = LIM_TAG_OPT; // never 90 or 91
            4'h9: r = LIM_TLV_LEN1;
            default: r = ob & LIM_OPT_NAD_MASK; // reserved bits sent as zero
        endcase
        return r;
    endfunction : lim_tx_at

    assign lc = opt_on ? LIM_CFG_LC_LONG : LIM_CFG_LC_SHORT;
    assign cmd_ready = (state == LIM_IDLE) && !session_start;
    assign tx_valid = (state == LIM_HDR) || (state == LIM_LC) || (state == LIM_DATA)
        || (state == LIM_LE);
    always_comb
    begin
        tx_byte = LIM_LE_ANY; // expected length 00
        if (state == LIM_HDR)
        begin
            tx_byte = lim_tx_at(cnt, op, p2, lc, high, opt);
        end
        else if (state == LIM_LC || state == LIM_DATA)
        begin
            tx_byte = lim_tx_at(cnt, op, p2, lc, high, opt);
        end
    end

    // command validity checked before anything is sent
    always_comb
    begin
        bad = 1'b0;
        if (cmd_op > LIM_OP_CONFIG)
        begin
            bad = 1'b1;
        end
        if (cmd_if > LIM_IF_MAX)
        begin
            bad = 1'b1;
        end
        if ((cmd_op == LIM_OP_RETRIEVE || cmd_op == LIM_OP_CONFIG) && cmd_if != LIM_ZERO)
        begin
            bad = 1'b1;
        end
        if (cmd_op == LIM_OP_SELECT && nad_mode)
        begin
            bad = 1'b1;
        end
        if (cmd_op == LIM_OP_CONFIG && configured)
        begin
            bad = 1'b1;
        end
    end

    always_comb
    begin
        next_state = state;
        next_op = op;
        next_p2 = p2;
        next_high = high;
        next_opt = opt;
        next_opt_on = opt_on;
        next_cnt = cnt;
        next_done = 1'b0;
        next_rejected = 1'b0;
        next_sw1 = sw1;
        next_sw2 = sw2;
        next_selected_if = selected_if;
        next_session_high = session_high;
        next_nad_mode = nad_mode;
        next_configured = configured;
        unique case (state)
            LIM_IDLE:
            begin
                if (cmd_valid && !session_start)
                begin
                    if (bad)
                    begin
                        next_rejected = 1'b1;
                    end
                    else
                    begin
                        next_op = cmd_op;
                        next_p2 = cmd_if;
                        next_high = cmd_high;
                        next_opt = cmd_opt;
                        next_opt_on = cmd_opt_present;
                        next_cnt = 4'h0;
                        next_state = LIM_HDR;
                    end
                end
            end
            LIM_HDR:
            begin
                if (tx_ready)
                begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == LIM_HDR_BYTES - 4'h1)
                    begin
                        if (op == LIM_OP_SELECT)
                        begin
                            next_state = LIM_RESP; // no lengths at all
                        end
                        else if (op == LIM_OP_CONFIG)
                        begin
                            next_state = LIM_LC;
                        end
                        else
                        begin
                            next_state = LIM_LE;
                        end
                    end
                end
            end
            LIM_LC:
            begin
                if (tx_ready)
                begin
                    next_cnt = cnt + 4'h1;
                    next_state = LIM_DATA;
                end
            end
            LIM_DATA:
            begin
                if (tx_ready)
                begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == LIM_HDR_BYTES + lc[3:0])
                    begin
                        next_state = LIM_LE;
                    end
                end
            end
            LIM_LE:
            begin
                if (tx_ready)
                begin
                    next_state = LIM_RESP;
                end
            end
            LIM_RESP:
            begin
                if (rx_valid_s2)
                begin
                    next_sw1 = sw2;
                    next_sw2 = rx_byte_s2;
                    if (rx_last_s2)
                    begin
                        next_state = LIM_DONE;
                    end
                end
            end
            LIM_DONE:
            begin
                next_done = 1'b1;
                next_state = LIM_IDLE;
                if (sw1 == LIM_SW_OK)
                begin
                    if (op != LIM_OP_RETRIEVE && op != LIM_OP_CONFIG)
                    begin
                        // select, reset and assign move the selection
                        next_selected_if = p2;
                    end
                    if (op == LIM_OP_CONFIG)
                    begin
                        next_configured = 1'b1;
                        // keep the answered maximum under our proposal
                        next_session_high = (p_high_seen && p_high <= high) ? p_high : high;
                        next_nad_mode = p_opt[0] & opt_on & opt[0];
                    end
                end
            end
            default:
            begin
                next_state = LIM_IDLE;
            end
        endcase
        if (session_start)
        begin
            next_state = LIM_IDLE;
            next_selected_if = LIM_ZERO;
            next_session_high = LIM_ZERO;
            next_nad_mode = 1'b0;
            next_configured = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= LIM_IDLE;
            op <= 8'h00;
            p2 <= 8'h00;
            high <= 8'h00;
            opt <= 8'h00;
            opt_on <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            rejected <= 1'b0;
            sw1 <= 8'h00;
            sw2 <= 8'h00;
            selected_if <= 8'h00;
            session_high <= 8'h00;
            nad_mode <= 1'b0;
            configured <= 1'b0;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            p2 <= next_p2;
            high <= next_high;
            opt <= next_opt;
            opt_on <= next_opt_on;
            cnt <= next_cnt;
            done <= next_done;
            rejected <= next_rejected;
            sw1 <= next_sw1;
            sw2 <= next_sw2;
            selected_if <= next_selected_if;
            session_high <= next_session_high;
            nad_mode <= next_nad_mode;
            configured <= next_configured;
        end
    end

    lim_resp_parse u_parse (
        .clk(clk),
        .rst_n(rst_n),
        .start(state == LIM_LE || (state == LIM_HDR && op == LIM_OP_SELECT)),
        .op(op),
        .rx_valid(state == LIM_RESP && rx_valid_s2),
        .rx_byte(rx_byte_s2),
        .high_if(p_high),
        .high_seen(p_high_seen),
        .opt_bits(p_opt),
        .assigned_if(p_assigned),
        .atr_len(atr_len),
        .data_byte(resp_byte),
        .data_strobe(resp_strobe)
    );
    assign assigned_if = p_assigned;
endmodule : lim_host
`default_nettype wire

/* verif/lim_host_props.sv */
// assertions on the ports of the interface manage command controller
`default_nettype none
module lim_host_props
    import lim_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic session_start,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_if,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic rejected,
    input wire logic [7:0] selected_if,
    input wire logic [7:0] session_high,
    input wire logic nad_mode,
    input wire logic configured
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence
    sequence s_refused;
        rejected && !tx_valid;
    endsequence
    property p_if_range;
        s_take ##0 (cmd_if > LIM_IF_MAX) |=> s_refused;
    endproperty
    a_if_range: assert property (p_if_range) else $error("interface above range sent");
    property p_op_reserved;
        s_take ##0 (cmd_op > LIM_OP_CONFIG) |=> s_refused;
    endproperty
    a_op_reserved: assert property (p_op_reserved) else $error("reserved code sent");
    property p_retrieve_if;
        s_take ##0 (cmd_op == LIM_OP_RETRIEVE && cmd_if != LIM_ZERO) |=> s_refused;
    endproperty
    a_retrieve_if: assert property (p_retrieve_if) else $error("retrieve with nonzero if");
    property p_config_if;
        s_take ##0 (cmd_op == LIM_OP_CONFIG && cmd_if != LIM_ZERO) |=> s_refused;
    endproperty
    a_config_if: assert property (p_config_if) else $error("configure with nonzero if");
    property p_no_select_nad;
        s_take ##0 (cmd_op == LIM_OP_SELECT && nad_mode) |=> s_refused;
    endproperty
    a_no_select_nad: assert property (p_no_select_nad) else $error("select in nad mode");
    property p_config_once;
        s_take ##0 (cmd_op == LIM_OP_CONFIG && configured) |=> s_refused;
    endproperty
    a_config_once: assert property (p_config_once) else $error("second configure sent");
    property p_reset_starts;
        s_take ##0 ((cmd_op == LIM_OP_RESET || cmd_op == LIM_OP_ASSIGN) && cmd_if <= LIM_IF_MAX)
            |=> tx_valid && tx_byte == LIM_CLA && !rejected;
    endproperty
    a_reset_starts: assert property (p_reset_starts) else $error("reset not sent");
    property p_byte_stands;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    a_byte_stands: assert property (p_byte_stands) else $error("byte dropped");
    property p_session_sel;
        session_start |-> ##[1:2] (selected_if == LIM_ZERO && !configured && !nad_mode);
    endproperty
    a_session_sel: assert property (p_session_sel) else $error("session not cleared");
    property p_high_bound;
        configured |-> session_high <= LIM_IF_MAX;
    endproperty
    a_high_bound: assert property (p_high_bound) else $error("session high too big");
    property p_nad_needs_cfg;
        nad_mode |-> configured;
    endproperty
    a_nad_needs_cfg: assert property (p_nad_needs_cfg) else $error("nad without configure");
endmodule : lim_host_props
bind lim_host lim_host_props u_props (.clk(clk), .reset_n(reset_n),
    .session_start(session_start), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_if(cmd_if), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .rejected(rejected), .selected_if(selected_if),
    .session_high(session_high), .nad_mode(nad_mode), .configured(configured));
`default_nettype wire

/* verif/lim_card_model.sv */
// behavioural card answering interface manage commands
`default_nettype none
module lim_card_model
    import lim_pkg::*;
#(
    parameter logic [7:0] CARD_MAX = 8'h1f,
    parameter logic [7:0] CARD_OPT = 8'h01
)
(
    input wire logic clk,
    input wire logic slow,
    input wire logic bad_sw,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] asg, lc, prop, topt, le;
    logic [7:0] hdr [4];
    logic [7:0] d [16];
    logic [7:0] q [$];
    int i;
    initial
    begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        rx_last = 1'b0;
        asg = LIM_NONE_ASSIGNED; // nothing assigned at power up
    end
    task automatic take(output logic [7:0] b);
        if (slow)
        begin
            tx_ready <= 1'b0;
            repeat (3) @(posedge clk);
        end
        tx_ready <= 1'b1;
        @(posedge clk);
        while (tx_valid !== 1'b1)
            @(posedge clk);
        b = tx_byte;
    endtask : take
    task automatic give(input logic [7:0] b, input logic l);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        rx_last <= l;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b; // idle line never repeats the last byte
        rx_last <= 1'b0;
    endtask : give
    always
    begin
        for (i = 0; i < 4; i++)
            take(hdr[i]);
        lc = 8'h00;
        if (hdr[2] == LIM_OP_CONFIG)
        begin
            take(lc);
            for (i = 0; i < lc; i++)
                take(d[i]);
        end
        if (hdr[2] != LIM_OP_SELECT)
            take(le);
        tx_ready <= 1'b0;
        repeat (slow ? 6 : 2) @(posedge clk);
        q.delete();
        case (hdr[2])
            LIM_OP_RESET, LIM_OP_ASSIGN: q = '{LIM_TAG_HIGH, 8'h02, 8'h3b, 8'h00};
            LIM_OP_RETRIEVE: q = '{LIM_TAG_HIGH, LIM_TLV_LEN1, asg};
            LIM_OP_CONFIG:
            begin
                prop = 8'h00;
                topt = 8'h00; // absent option object reads as zero
                i = 0;
                while (i + 2 < lc)
                begin
                    if (d[i] == LIM_TAG_HIGH)
                        prop = d[i+2];
                    if (d[i] == LIM_TAG_OPT)
                        topt = d[i+2];
                    i = i + 2 + d[i+1]; // other objects skipped
                end
                if (prop > CARD_MAX)
                    prop = CARD_MAX;
                q = '{LIM_TAG_HIGH, LIM_TLV_LEN1, prop, LIM_TAG_OPT, LIM_TLV_LEN1,
                    topt & CARD_OPT & LIM_OPT_NAD_MASK};
            end
            default: ;
        endcase
        if (bad_sw)
            q = '{8'h6a, 8'h86}; // forced refusal leaves state alone
        else
        begin
            q.push_back(LIM_SW_OK);
            q.push_back(8'h00);
            if (hdr[2] == LIM_OP_ASSIGN)
                asg = hdr[3];
        end
        for (i = 0; i < q.size(); i++)
            give(q[i], i == q.size() - 1);
    end
endmodule : lim_card_model
`default_nettype wire

/* verif/lim_host_tb.sv */
// self-checking bench for the interface manage command controller
`default_nettype none
module lim_host_tb
    import lim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, session_start, cmd_valid, cmd_ready, cmd_opt_present, slow, bad_sw;
    logic [7:0] cmd_op, cmd_if, cmd_high, cmd_opt, tx_byte, rx_byte, sw1, sw2;
    logic [7:0] selected_if, session_high, assigned_if, atr_len, resp_byte;
    logic resp_strobe;
    logic tx_valid, tx_ready, rx_valid, rx_last, done, rejected, nad_mode, configured, got_rej;
    logic [7:0] txq [$];
    int err_total, check_count, i, rsp_cnt;
    logic [7:0] ops [5] = '{8'h05, 8'hff, 8'h01, 8'h03, 8'h04};
    logic [7:0] ifs [5] = '{8'h00, 8'h00, 8'h20, 8'h01, 8'h01};
    lim_host u_dut (.clk(clk), .reset_n(reset_n), .session_start(session_start),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_if(cmd_if),
        .cmd_high(cmd_high), .cmd_opt(cmd_opt), .cmd_opt_present(cmd_opt_present),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_last(rx_last), .done(done), .rejected(rejected), .sw1(sw1),
        .sw2(sw2), .selected_if(selected_if), .session_high(session_high),
        .nad_mode(nad_mode), .assigned_if(assigned_if), .atr_len(atr_len), .resp_byte(resp_byte),
        .resp_strobe(resp_strobe), .configured(configured));
    lim_card_model u_card (.clk(clk), .slow(slow), .bad_sw(bad_sw), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_last(rx_last));
    always #2 clk = ~clk;
    always @(posedge clk)
        if (tx_valid && tx_ready)
            txq.push_back(tx_byte);
    always @(posedge clk) rsp_cnt += int'(resp_strobe === 1'b1);
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bound(input int n);
        if (n > 400)
        begin
            err_total++;
            give_verdict();
        end
    endtask : bound
    task automatic cmd(input logic [7:0] op, pif, hi, opt, input logic opp);
        int n;
        txq.delete();
        rsp_cnt = 0;
        @(negedge clk);
        cmd_op = op;
        cmd_if = pif;
        cmd_high = hi;
        cmd_opt = opt;
        cmd_opt_present = opp;
        cmd_valid = 1'b1;
        n = 0;
        @(posedge clk);
        while (!cmd_ready)
        begin
            bound(n++);
            @(posedge clk);
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        while (!(done || rejected))
        begin
            bound(n++);
            @(negedge clk);
        end
        got_rej = rejected;
        @(negedge clk);
    endtask : cmd
    task automatic chk_tx(input logic [95:0] exp, input int n);
        chk(8'(txq.size()), 8'(n));
        if (txq.size() == n)
            for (int k = 0; k < n; k++)
                chk(txq[k], exp[8*(n-1-k) +: 8]);
    endtask : chk_tx
    task automatic t_reset_state();
        chk(selected_if, LIM_ZERO);
        chk(assigned_if, LIM_NONE_ASSIGNED);
        chk({6'h00, configured, nad_mode}, 8'h00);
        cmd(LIM_OP_RETRIEVE, 8'h00, 8'h00, 8'h00, 1'b0);
        chk_tx(40'h8076030000, 5);
        chk(assigned_if, LIM_NONE_ASSIGNED);
    endtask : t_reset_state
    task automatic t_select_reset_assign();
        cmd(LIM_OP_SELECT, 8'h05, 8'h00, 8'h00, 1'b0);
        chk_tx(32'h80760005, 4);
        chk(selected_if, 8'h05);
        cmd(LIM_OP_RESET, 8'h1f, 8'h00, 8'h00, 1'b0);
        chk_tx(40'h8076011f00, 5);
        chk(selected_if, 8'h1f);
        chk(atr_len, 8'h02);
        cmd(LIM_OP_ASSIGN, 8'h03, 8'h00, 8'h00, 1'b0);
        chk_tx(40'h8076020300, 5);
        chk(selected_if, 8'h03);
        cmd(LIM_OP_RETRIEVE, 8'h00, 8'h00, 8'h00, 1'b0);
        chk(assigned_if, 8'h03);
    endtask : t_select_reset_assign
    task automatic t_refused();
        for (i = 0; i < 5; i++)
        begin
            cmd(ops[i], ifs[i], 8'h00, 8'h00, 1'b0);
            chk({7'h00, got_rej}, 8'h01);
            chk(8'(txq.size()), 8'h00);
            chk(selected_if, 8'h03);
        end
    endtask : t_refused
    task automatic t_configure();
        cmd(LIM_OP_CONFIG, 8'h00, 8'h40, 8'hff, 1'b1);
        chk_tx(96'h807604000680014081010100, 12);
        chk(session_high, 8'h1f);
        chk({6'h00, configured, nad_mode}, 8'h03);
        cmd(LIM_OP_SELECT, 8'h02, 8'h00, 8'h00, 1'b0);
        chk({7'h00, got_rej}, 8'h01);
        cmd(LIM_OP_CONFIG, 8'h00, 8'h05, 8'h00, 1'b0);
        chk({7'h00, got_rej}, 8'h01);
    endtask : t_configure
    task automatic t_new_session();
        @(negedge clk);
        session_start = 1'b1;
        slow = 1'b1;
        @(negedge clk);
        session_start = 1'b0;
        @(negedge clk);
        chk(selected_if, LIM_ZERO);
        chk({6'h00, configured, nad_mode}, 8'h00);
        cmd(LIM_OP_CONFIG, 8'h00, 8'h05, 8'h00, 1'b0);
        chk_tx(72'h807604000380010500, 9);
        chk(session_high, 8'h05);
        chk({7'h00, nad_mode}, 8'h00);
    endtask : t_new_session
    task automatic t_card_error();
        bad_sw = 1'b1;
        cmd(LIM_OP_RESET, 8'h07, 8'h00, 8'h00, 1'b0);
        chk(sw1, 8'h6a);
        chk(sw2, 8'h86);
        chk(resp_byte, 8'h86);
        chk(8'(rsp_cnt), 8'h02);
        chk(selected_if, LIM_ZERO);
        bad_sw = 1'b0;
    endtask : t_card_error
    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        {session_start, cmd_valid, cmd_opt_present, slow, bad_sw, got_rej} = 6'h00;
        {cmd_op, cmd_if, cmd_high, cmd_opt} = 32'h00000000;
        err_total = 0;
        check_count = 0;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset_state();
        t_select_reset_assign();
        t_refused();
        t_configure();
        t_new_session();
        t_card_error();
        give_verdict();
    end
endmodule : lim_host_tb
`default_nettype wire
